// ---- rtl/sqfl_pkg.sv ----
package sqfl_pkg;

  // ****************************************************************
  // Timing figures, counted in switching oscillator cycles.
  // ****************************************************************
  localparam int unsigned PHASE_CYCLES     = 1024;
  localparam int unsigned SOFT_FULL_CYCLES = 3072;
  localparam int unsigned PUMP_CYCLES      = 4096;
  localparam int unsigned TMR_W            = 13;
  localparam logic [1:0]  PHASE_RESET      = 2'h0;
  localparam logic [1:0]  PHASE_FULL       = 2'h3;

  typedef enum logic [2:0] {
    SQFL_OFF,
    SQFL_REF_UP,
    SQFL_MAIN_UP,
    SQFL_NEG_UP,
    SQFL_POS_UP,
    SQFL_READY,
    SQFL_FAULT
  } sqfl_state_t;

endpackage

// ---- rtl/sqfl_sequencer.sv ----
// How it works
// - Shutdown low disables all converters and reference; high starts sequence.
// - In shutdown the reference output is pulled to ground.
// - Any transition on the shutdown input clears the latched fault once the die is cool.
// - Reference enables first, then main boost with soft-start active.
// - Regulator enables with main boost; it never affects sequence or ready.
// - Negative pump enables on first main comparator change; comparator held low.
// - Positive pump starts once negative feedback falls below its threshold.
// - Positive feedback above threshold asserts ready low, enables buffer.
// - Pumpless variants still insert two 4096-cycle delays before ready.
// - Soft-start has four phases; the first limits to a quarter.
// - Without regulation each phase interval advances a phase and limit.
// - Full limit after 3072 cycles or at regulation, whichever first.
// - Each pump waits on its feedback; the 4096-cycle period applies only when pumpless.
// - Grounded fault-level pin selects preset threshold, else external level.
// - After ready, undervoltage latches fault, releases ready, keeps reference.
// - Fault trips on low reference or negative feedback above threshold.
// - Overtemperature sets the fault; clears only after the die cools.
`timescale 1ns/1ps
`default_nettype none
module sqfl_sequencer
  import sqfl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       osc_tick,
  input  wire logic       shutdown_n_input,
  input  wire logic       pumps_present,
  input  wire logic       fault_level_select,
  input  wire logic       ref_ok,
  input  wire logic       main_reg_cmp,
  input  wire logic       main_uv_preset,
  input  wire logic       main_uv_ext,
  input  wire logic       neg_pump_feedback,
  input  wire logic       neg_pump_fault,
  input  wire logic       pos_pump_feedback,
  input  wire logic       pos_uv_preset,
  input  wire logic       pos_uv_ext,
  input  wire logic       input_uv,
  input  wire logic       over_temp,
  input  wire logic       cooled,
  output logic            ref_enable,
  output logic            ref_pulldown,
  output logic            main_enable,
  output logic            ldo_enable,
  output logic            neg_pump_enable,
  output logic            pos_pump_enable,
  output logic            backplane_buffer,
  output logic            main_cmp_gated,
  output logic [1:0]      soft_phase,
  output logic            ready_n_oe,
  output logic            ready_n_out,
  output logic            fault_latched
);

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  localparam int NIN = 14;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;

  assign raw_in = {shutdown_n_input, pumps_present, fault_level_select,
                   ref_ok, main_reg_cmp, main_uv_preset, main_uv_ext,
                   neg_pump_feedback, neg_pump_fault, pos_pump_feedback,
                   pos_uv_preset, pos_uv_ext, input_uv,
                   over_temp | ~cooled};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  logic s_shutdown_n_input_n;
  logic s_pumps;
  logic s_flt_ext;
  logic s_ref_ok;
  logic s_main_cmp;
  logic s_main_uv_pre;
  logic s_main_uv_ext;
  logic s_neg_low;
  logic s_neg_fault;
  logic s_pos_high;
  logic s_pos_uv_pre;
  logic s_pos_uv_ext;
  logic s_in_uv;
  logic s_hot;

  assign {s_shutdown_n_input_n, s_pumps, s_flt_ext, s_ref_ok, s_main_cmp,
          s_main_uv_pre, s_main_uv_ext, s_neg_low, s_neg_fault,
          s_pos_high, s_pos_uv_pre, s_pos_uv_ext, s_in_uv,
          s_hot} = sync2_r;

  // ****************************************************************
  // Shutdown edge detection.
  // ****************************************************************
  logic shutdown_n_input_prev_r;
  logic shutdown_n_input_edge;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shutdown_n_input_prev_r <= 1'b0;
    end else begin
      shutdown_n_input_prev_r <= s_shutdown_n_input_n;
    end
  end

  assign shutdown_n_input_edge = shutdown_n_input_prev_r ^ s_shutdown_n_input_n;

  // ****************************************************************
  // Fault detection.
  // ****************************************************************
  logic main_uv;
  logic pos_uv;
  logic uv_fault;
  logic trip;

  assign main_uv  = s_flt_ext ? s_main_uv_ext : s_main_uv_pre;
  assign pos_uv   = s_flt_ext ? s_pos_uv_ext : s_pos_uv_pre;

  sqfl_state_t state_r;
  sqfl_state_t state_nxt;

  assign uv_fault = (state_r == SQFL_READY) &&
                    (main_uv || pos_uv || s_in_uv ||
                     (s_pumps && s_neg_fault));
  assign trip     = uv_fault || (!s_ref_ok && state_r != SQFL_OFF &&
                    state_r != SQFL_REF_UP) ||
                    (s_pumps && s_neg_fault && state_r == SQFL_READY) ||
                    s_hot;

  logic fault_r;

  // A trip in the same cycle as a rising shutdown edge keeps the latch set.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_r <= 1'b0;
    end else if (trip && s_shutdown_n_input_n) begin
      fault_r <= 1'b1;
    end else if (shutdown_n_input_edge && !s_hot) begin
      fault_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Timers in oscillator cycles.
  // ****************************************************************
  logic [TMR_W-1:0] soft_cnt_r;
  logic [TMR_W-1:0] pump_cnt_r;
  logic             main_reg_seen_r;
  logic             pump_done;

  assign pump_done = (pump_cnt_r == TMR_W'(PUMP_CYCLES - 1)) && osc_tick;

  always_ff @(posedge ref_clk) begin
    if (srst || state_r == SQFL_OFF || state_r == SQFL_FAULT) begin
      soft_cnt_r <= '0;
    end else if (state_r != SQFL_REF_UP && osc_tick &&
                 soft_cnt_r != TMR_W'(SOFT_FULL_CYCLES)) begin
      soft_cnt_r <= soft_cnt_r + TMR_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || state_r != state_nxt ||
        state_r == SQFL_OFF || state_r == SQFL_FAULT) begin
      pump_cnt_r <= '0;
    end else if (osc_tick && (state_r == SQFL_NEG_UP ||
                              state_r == SQFL_POS_UP)) begin
      pump_cnt_r <= pump_cnt_r + TMR_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || state_r == SQFL_OFF || state_r == SQFL_FAULT) begin
      main_reg_seen_r <= 1'b0;
    end else if (state_r == SQFL_MAIN_UP && s_main_cmp) begin
      main_reg_seen_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Soft-start current-limit phase.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst || state_r == SQFL_OFF || state_r == SQFL_FAULT ||
        state_r == SQFL_REF_UP) begin
      soft_phase <= PHASE_RESET;
    end else if (main_reg_seen_r || state_r != SQFL_MAIN_UP) begin
      soft_phase <= PHASE_FULL;
    end else if (soft_cnt_r >= TMR_W'(SOFT_FULL_CYCLES)) begin
      soft_phase <= PHASE_FULL;
    end else begin
      soft_phase <= 2'(soft_cnt_r / TMR_W'(PHASE_CYCLES));
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= SQFL_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SQFL_OFF: begin
        if (s_shutdown_n_input_n && !fault_r) begin
          state_nxt = SQFL_REF_UP;
        end
      end
      SQFL_REF_UP: begin
        if (s_ref_ok) begin
          state_nxt = SQFL_MAIN_UP;
        end
      end
      SQFL_MAIN_UP: begin
        if (s_main_cmp) begin
          state_nxt = SQFL_NEG_UP;
        end
      end
      SQFL_NEG_UP: begin
        if (s_pumps ? s_neg_low : pump_done) begin
          state_nxt = SQFL_POS_UP;
        end
      end
      SQFL_POS_UP: begin
        if (s_pumps ? s_pos_high : pump_done) begin
          state_nxt = SQFL_READY;
        end
      end
      SQFL_READY: begin
        state_nxt = SQFL_READY;
      end
      SQFL_FAULT: begin
        if (!fault_r) begin
          state_nxt = SQFL_OFF;
        end
      end
      default: begin
        state_nxt = SQFL_OFF;
      end
    endcase
    if (!s_shutdown_n_input_n) begin
      state_nxt = SQFL_OFF;
    end else if (fault_r && state_r != SQFL_OFF) begin
      state_nxt = SQFL_FAULT;
    end
  end

  // ****************************************************************
  // Output enables, all registered.
  // ****************************************************************
  logic run;

  assign run = state_r != SQFL_OFF && state_r != SQFL_FAULT &&
               state_r != SQFL_REF_UP;

  // ****************************************************************
  // Reference.
  // ****************************************************************
  // The reference stays up through a fault; only shutdown grounds it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_enable   <= 1'b0;
      ref_pulldown <= 1'b1;
    end else begin
      ref_enable   <= state_r != SQFL_OFF;
      ref_pulldown <= state_r == SQFL_OFF;
    end
  end

  // ****************************************************************
  // Main converter and linear regulator.
  // ****************************************************************
  // The regulator follows the main enable only; nothing reads it back.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      main_enable <= 1'b0;
      ldo_enable  <= 1'b0;
    end else begin
      main_enable <= run;
      ldo_enable  <= run;
    end
  end

  // ****************************************************************
  // Charge pumps.
  // ****************************************************************
  // Pumpless variants keep both enables low but still run the timers.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      neg_pump_enable <= 1'b0;
      pos_pump_enable <= 1'b0;
    end else begin
      neg_pump_enable <= run && state_r != SQFL_MAIN_UP && s_pumps;
      pos_pump_enable <= s_pumps && (state_r == SQFL_POS_UP ||
                         state_r == SQFL_READY);
    end
  end

  // ****************************************************************
  // Gated regulation comparator.
  // ****************************************************************
  // The comparator reads low until main regulation is first seen.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      main_cmp_gated <= 1'b0;
    end else begin
      main_cmp_gated <= run && state_r != SQFL_MAIN_UP && s_main_cmp;
    end
  end

  // ****************************************************************
  // Ready pin and backplane buffer.
  // ****************************************************************
  // Ready is open drain: the enable pulls the pin low, and a release
  // lets the pull-up show a fault or an unfinished sequence.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_n_oe       <= 1'b0;
      backplane_buffer <= 1'b0;
    end else begin
      ready_n_oe       <= state_r == SQFL_READY;
      backplane_buffer <= state_r == SQFL_READY;
    end
  end

  assign ready_n_out = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_latched <= 1'b0;
    end else begin
      fault_latched <= fault_r;
    end
  end

endmodule
`default_nettype wire

// ---- test/sqfl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sqfl_checker
  import sqfl_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       shutdown_n_input,
  input wire logic       ref_enable,
  input wire logic       ref_pulldown,
  input wire logic       main_enable,
  input wire logic       ldo_enable,
  input wire logic       neg_pump_enable,
  input wire logic       pos_pump_enable,
  input wire logic       backplane_buffer,
  input wire logic [1:0] soft_phase,
  input wire logic       ready_n_oe,
  input wire logic       fault_latched
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_shutdown_all_off: assert property (!shutdown_n_input [*5] |->
    !ref_enable && ref_pulldown && !main_enable) else $error("off fail");
  a_ldo_with_main: assert property (ldo_enable == main_enable)
    else $error("ldo fail");
  a_neg_after_main: assert property ($rose(neg_pump_enable) |->
    main_enable) else $error("neg order fail");
  a_pos_after_neg: assert property ($rose(pos_pump_enable) |->
    neg_pump_enable) else $error("pos order fail");
  a_ready_buffer: assert property (ready_n_oe == backplane_buffer)
    else $error("buffer fail");
  a_ready_seq_done: assert property ($rose(ready_n_oe) |->
    main_enable && ref_enable && soft_phase == PHASE_FULL)
    else $error("ready early");
  a_fault_shuts_out: assert property ($rose(fault_latched) |->
    ##[0:2] (!ready_n_oe && !main_enable && !neg_pump_enable &&
    !pos_pump_enable)) else $error("fault fail");
  a_phase_step_up: assert property (main_enable && $past(main_enable) &&
    $changed(soft_phase) |-> soft_phase == $past(soft_phase) + 2'h1 ||
    soft_phase == PHASE_FULL) else $error("phase step fail");
  a_phase_clear: assert property (!main_enable &&
    $past(main_enable) == 1'b0 |-> soft_phase == PHASE_RESET)
    else $error("phase clear fail");
  c_ready: cover property ($rose(ready_n_oe));
  c_fault: cover property ($rose(fault_latched));
  c_full: cover property (main_enable && soft_phase == PHASE_FULL);
endmodule
bind sqfl_sequencer sqfl_checker chk (
  .ref_clk, .srst, .shutdown_n_input, .ref_enable, .ref_pulldown,
  .main_enable, .ldo_enable, .neg_pump_enable, .pos_pump_enable,
  .backplane_buffer, .soft_phase, .ready_n_oe, .fault_latched
);
`default_nettype wire

// ---- test/sqfl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sqfl_host_model (
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic ready_n_oe,
  input  wire logic ready_n_out,
  output logic      shutdown_n_input,
  output logic      ready_pin
);
  // Shutdown follows the run request; a fall or a rise clears a fault.
  always @(posedge ref_clk) shutdown_n_input <= run;
  // The ready line has a pull-up, so a released drain reads high.
  assign ready_pin = ready_n_oe ? ready_n_out : 1'b1;
endmodule
`default_nettype wire

// ---- test/supply_sequencer_fault_latch_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module supply_sequencer_fault_latch_tb_top
  import sqfl_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       osc_tick = 1'b0;
  logic       srst, run, pumps_present, cooled;
  logic       fault_level_select, ref_ok, main_reg_cmp, over_temp;
  logic       neg_pump_feedback, pos_pump_feedback, shutdown_n_input;
  logic       ref_enable, ref_pulldown, main_enable, ldo_enable;
  logic       neg_pump_enable, pos_pump_enable, backplane_buffer;
  logic       main_cmp_gated, ready_n_oe, ready_n_out, fault_latched;
  logic       ready_pin;
  logic [1:0] soft_phase;
  logic [5:0] flt;
  logic [4:0] seq_out;
  logic [8:0] rows [5] = '{9'h010, 9'h118, 9'h19C, 9'h1DE, 9'h1FF};
  int         err_total = 0, checked = 0, n, m;
  assign seq_out = {ref_enable, main_enable, neg_pump_enable,
                    pos_pump_enable, ready_n_oe};
  sqfl_sequencer uut (
    .ref_clk, .srst, .osc_tick, .shutdown_n_input, .pumps_present,
    .fault_level_select, .ref_ok, .main_reg_cmp, .main_uv_preset(flt[5]),
    .main_uv_ext(flt[4]), .neg_pump_feedback, .neg_pump_fault(flt[0]),
    .pos_pump_feedback, .pos_uv_preset(flt[3]), .pos_uv_ext(flt[2]),
    .input_uv(flt[1]), .over_temp, .cooled, .ref_enable, .ref_pulldown,
    .main_enable, .ldo_enable, .neg_pump_enable, .pos_pump_enable,
    .backplane_buffer, .main_cmp_gated, .soft_phase, .ready_n_oe,
    .ready_n_out, .fault_latched
  );
  sqfl_host_model host (
    .ref_clk, .run, .ready_n_oe, .ready_n_out, .shutdown_n_input,
    .ready_pin
  );
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) osc_tick <= ~osc_tick;
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic down();
    run <= 1'b0;
    cyc(8);
  endtask
  task automatic up();
    run <= 1'b1;
    {ref_ok, main_reg_cmp, neg_pump_feedback, pos_pump_feedback} <= 4'hF;
    for (n = 0; n < 200 && ready_n_oe !== 1'b1; n++) cyc(1);
    `CHK(ready_pin, 1'b0)
  endtask
  task automatic wait_main();
    for (m = 0; m < 100 && main_enable !== 1'b1; m++) cyc(1);
  endtask
  initial begin
    cyc(60000);
    err_total++;
    $display("mismatch at %0t: watchdog", $time);
    conclude();
  end
  initial begin
    {run, fault_level_select, over_temp} = '0;
    {ref_ok, main_reg_cmp, neg_pump_feedback, pos_pump_feedback} = '0;
    {srst, pumps_present, cooled, flt} = 9'h1C0;
    cyc(6);
    srst <= 1'b0;
    cyc(4);
    `CHK({ref_enable, ref_pulldown, soft_phase}, 4'h4)
    run <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      {ref_ok, main_reg_cmp, neg_pump_feedback, pos_pump_feedback}
        <= rows[i][8:5];
      cyc(10);
      `CHK(seq_out, rows[i][4:0])
    end
    `CHK({main_cmp_gated, ldo_enable, backplane_buffer}, 3'h7)
    note("sequence");
    for (int i = 0; i < 6; i++) begin
      down();
      fault_level_select <= (i == 4 || i == 2);
      up();
      flt[i] <= 1'b1;
      cyc(8);
      `CHK({fault_latched, ready_pin, ref_enable, main_enable}, 4'hE)
      flt[i] <= 1'b0;
      down();
      `CHK({fault_latched, ref_pulldown, ref_enable}, 3'h2)
    end
    fault_level_select <= 1'b1;
    up();
    flt[5] <= 1'b1;
    cyc(10);
    `CHK(fault_latched, 1'b0)
    flt[5] <= 1'b0;
    ref_ok <= 1'b0;
    cyc(8);
    `CHK(fault_latched, 1'b1)
    srst <= 1'b1;
    cyc(2);
    `CHK({fault_latched, ready_n_oe, soft_phase}, 4'h0)
    srst <= 1'b0;
    note("faults");
    up();
    cooled <= 1'b0;
    over_temp <= 1'b1;
    cyc(8);
    `CHK(fault_latched, 1'b1)
    over_temp <= 1'b0;
    down();
    `CHK(fault_latched, 1'b1)
    cooled <= 1'b1;
    cyc(4);
    run <= 1'b1;
    cyc(8);
    `CHK(fault_latched, 1'b0)
    note("thermal");
    down();
    pumps_present <= 1'b0;
    run <= 1'b1;
    wait_main();
    for (n = 0; m < 30000 && ready_n_oe !== 1'b1; m++) begin
      cyc(1);
      n += osc_tick;
    end
    `CHK(n >= 2 * PUMP_CYCLES && n <= 2 * PUMP_CYCLES + 16, 1'b1)
    `CHK(seq_out, 5'h19)
    note("pumpless");
    down();
    pumps_present <= 1'b1;
    main_reg_cmp <= 1'b0;
    run <= 1'b1;
    wait_main();
    `CHK({soft_phase, main_cmp_gated}, 3'h0)
    for (n = 0; m < 30000 && soft_phase !== PHASE_FULL; m++) begin
      cyc(1);
      n += osc_tick;
    end
    `CHK(n >= SOFT_FULL_CYCLES - 4 && n <= SOFT_FULL_CYCLES + 4, 1'b1)
    down();
    run <= 1'b1;
    wait_main();
    cyc(20);
    main_reg_cmp <= 1'b1;
    cyc(6);
    `CHK(soft_phase, PHASE_FULL)
    note("softstart");
    conclude();
  end
endmodule
`default_nettype wire
